/* verilog/fbepc_ctrl.sv */
// flash bank select, erase launch, program write enable and fuse override
`timescale 1ns/1ps
module fbepc_ctrl #(
	parameter int BUSY_CYCLES = fbepc_pkg::ERASE_BUSY_CYCLES
) (
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	// special-function register port from the core
	input  wire logic [13:0]             regAddr,
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	input  wire logic [7:0]              regWdata,
	output logic [7:0]                   regRdata,
	// core state
	input  wire logic                    intEnable,
	input  wire logic                    debugPortEnable,
	// core external-data moves
	input  wire logic [15:0]             codeAddr,
	input  wire logic [15:0]             dataPointer,
	input  wire logic [7:0]              accumulator,
	input  wire logic                    xdataStore,
	// fuse register
	input  wire logic [7:0]              fuseValue,
	output logic [7:0]                   fuseEffective,
	// flash array side and data RAM store
	output logic [17:0]                  flashReadAddr,
	output logic                         flashProgStrobe,
	output logic [17:0]                  flashProgAddr,
	output logic [7:0]                   flashProgData,
	output logic                         pageEraseStart,
	output logic                         massEraseStart,
	output logic [6:0]                   erasePage,
	output logic                         eraseBusy,
	output logic                         dataRamStore
);
	typedef struct packed {
		logic [2:0]                   bank;
		logic [5:0]                   page;
		logic                         arm;
		logic                         pwe;
		logic                         fovr;
		logic [7:0]                   fuseOvr;
		logic [7:0]                   fuseEff;
		logic [7:0]                   rdata;
		logic [17:0]                  readAddr;
		logic                         progStrobe;
		logic [17:0]                  progAddr;
		logic [7:0]                   progData;
		logic                         pageStart;
		logic                         massStart;
		logic [6:0]                   erPage;
		fbepc_pkg::fbepc_erase_type   erState;
		logic [7:0]                   busyCnt;
		logic                         ramStore;
		logic                         busy;
	} fbepc_state_type;

	fbepc_state_type state_ff;
	fbepc_state_type nxt_state;
	logic [17:0]     mapRead;
	logic [17:0]     mapStore;
	// decoded register writes, erase conditions and store routing
	logic            wrBank;
	logic            wrPage;
	logic            wrProg;
	logic            wrFuse;
	logic            wrErase;
	logic            patPage;
	logic            patMass;
	logic            patDone;
	logic            eraseIdle;
	logic            countDone;
	logic            pageGo;
	logic            massGo;
	logic            doneGo;
	logic            pweGo;
	logic            storeFlash;
	logic            storeRam;
	logic [6:0]      pageNumber;

	fbepc_addr_map #(.BANK_W(fbepc_pkg::BANK_WIDTH)) uReadMap (
		.coreAddr  (codeAddr),
		.bankSel   (state_ff.bank),
		.flashAddr (mapRead)
	);
	fbepc_addr_map #(.BANK_W(fbepc_pkg::BANK_WIDTH)) uStoreMap (
		.coreAddr  (dataPointer),
		.bankSel   (state_ff.bank),
		.flashAddr (mapStore)
	);

	// one strobe per register; bank is also reloaded when an erase launches, page on a page erase, arm on a mass erase
	assign wrBank     = regWrite && regAddr == fbepc_pkg::BANK_SELECT_ADDR;
	assign wrPage     = regWrite && regAddr == fbepc_pkg::PAGE_ERASE_ADDR;
	assign wrProg     = regWrite && regAddr == fbepc_pkg::PROG_CTRL_ADDR;
	assign wrFuse     = regWrite && regAddr == fbepc_pkg::FUSE_CTRL_ADDR;
	assign wrErase    = regWrite && regAddr == fbepc_pkg::ERASE_COMMAND_ADDR;

	assign patPage    = regWdata == fbepc_pkg::PAGE_ERASE_PATTERN;
	assign patMass    = regWdata == fbepc_pkg::MASS_ERASE_PATTERN;
	assign patDone    = regWdata == fbepc_pkg::ERASE_DONE_PATTERN;
	assign eraseIdle  = state_ff.erState == fbepc_pkg::FBEPC_IDLE;
	assign countDone  = state_ff.busyCnt == 8'h00;

	assign pageGo     = wrErase && patPage && eraseIdle;
	assign massGo     = wrErase && patMass && eraseIdle && state_ff.arm && debugPortEnable;
	// an early done pattern is ignored so a cycle never ends before its minimum time
	assign doneGo     = wrErase && patDone && !eraseIdle && countDone;
	assign pweGo      = wrProg && !intEnable;
	// bank and page form page number
	assign pageNumber = {state_ff.bank[0], state_ff.page};
	// store routing by program write enable
	assign storeFlash = xdataStore && state_ff.pwe;
	assign storeRam   = xdataStore && !state_ff.pwe;

	always_comb begin
		nxt_state            = state_ff;
		nxt_state.pageStart  = 1'b0;
		nxt_state.massStart  = 1'b0;
		nxt_state.progStrobe = 1'b0;
		nxt_state.ramStore   = 1'b0;
		nxt_state.readAddr   = mapRead;
		if (wrBank) begin
			nxt_state.bank = regWdata[fbepc_pkg::BANK_WIDTH-1:0];
		end
		if (wrPage) begin
			nxt_state.page = regWdata[fbepc_pkg::PAGE_LSB +: fbepc_pkg::PAGE_WIDTH];
		end
		if (wrProg) begin
			nxt_state.arm = regWdata[fbepc_pkg::ARM_BIT];
		end
		// arming is still taken while interrupts are on; only the enable bit is held
		if (pweGo) begin
			nxt_state.pwe = regWdata[fbepc_pkg::PWE_BIT];
		end
		if (wrFuse) begin
			nxt_state.fovr = regWdata[fbepc_pkg::FOVR_BIT];
			if (state_ff.fovr) begin
				nxt_state.fuseOvr = regWdata;
			end
		end

		// erase sequencing: launches only from idle, so a running cycle is never restarted
		case (state_ff.erState)
			fbepc_pkg::FBEPC_IDLE: begin
				if (pageGo) begin
					nxt_state.pageStart = 1'h1;
					nxt_state.erPage    = pageNumber;
					nxt_state.erState   = fbepc_pkg::FBEPC_PAGE;
					nxt_state.busyCnt   = 8'(BUSY_CYCLES);
					nxt_state.page      = fbepc_pkg::PAGE_RESET;
					nxt_state.bank      = fbepc_pkg::BANK_RESET;
				end else if (massGo) begin
					nxt_state.massStart = 1'h1;
					nxt_state.erState   = fbepc_pkg::FBEPC_MASS;
					nxt_state.busyCnt   = 8'(BUSY_CYCLES);
					nxt_state.arm       = 1'h0;
					nxt_state.bank      = fbepc_pkg::BANK_RESET;
				end
			end
			fbepc_pkg::FBEPC_PAGE: begin
				if (!countDone) begin
					nxt_state.busyCnt = state_ff.busyCnt - 8'h01;
				end
				if (doneGo) begin
					nxt_state.erState = fbepc_pkg::FBEPC_IDLE;
				end
			end
			fbepc_pkg::FBEPC_MASS: begin
				if (!countDone) begin
					nxt_state.busyCnt = state_ff.busyCnt - 8'h01;
				end
				if (doneGo) begin
					nxt_state.erState = fbepc_pkg::FBEPC_IDLE;
				end
			end
			default: begin
				nxt_state.erState = fbepc_pkg::FBEPC_IDLE;
				nxt_state.busyCnt = 8'h00;
			end
		endcase
		nxt_state.busy = nxt_state.erState != fbepc_pkg::FBEPC_IDLE;

		// override value is taken from the registered copy, two cycles after the write
		nxt_state.fuseEff = state_ff.fovr ? state_ff.fuseOvr : fuseValue;

		if (storeFlash) begin
			nxt_state.progStrobe = 1'h1;
			nxt_state.progAddr   = mapStore;
			nxt_state.progData   = accumulator;
		end
		if (storeRam) begin
			nxt_state.ramStore = 1'h1;
		end
		// read data moves only on a read, so it stands until the core asks again
		if (regRead) begin
			case (regAddr)
				fbepc_pkg::BANK_SELECT_ADDR: begin
					nxt_state.rdata = {5'h00, state_ff.bank};
				end
				fbepc_pkg::PROG_CTRL_ADDR: begin
					// arming bit is write only and reads back as zero
					nxt_state.rdata = {7'h00, state_ff.pwe};
				end
				fbepc_pkg::FUSE_CTRL_ADDR: begin
					nxt_state.rdata = {3'h0, state_ff.fovr, 4'h0};
				end
				default: begin
					nxt_state.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff.bank       <= fbepc_pkg::BANK_RESET;
			state_ff.page       <= fbepc_pkg::PAGE_RESET;
			state_ff.arm        <= 1'h0;
			state_ff.pwe        <= 1'h0;
			state_ff.fovr       <= 1'h0;
			state_ff.fuseOvr    <= 8'h00;
			state_ff.fuseEff    <= 8'h00;
			state_ff.rdata      <= 8'h00;
			state_ff.readAddr   <= 18'h00000;
			state_ff.progStrobe <= 1'h0;
			state_ff.progAddr   <= 18'h00000;
			state_ff.progData   <= 8'h00;
			state_ff.pageStart  <= 1'h0;
			state_ff.massStart  <= 1'h0;
			state_ff.erPage     <= 7'h00;
			state_ff.erState    <= fbepc_pkg::FBEPC_IDLE;
			state_ff.busyCnt    <= 8'h00;
			state_ff.busy       <= 1'h0;
			state_ff.ramStore   <= 1'h0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// every output is a field of the registered state
	assign regRdata        = state_ff.rdata;
	assign fuseEffective   = state_ff.fuseEff;
	// flash read and program side
	assign flashReadAddr   = state_ff.readAddr;
	assign flashProgStrobe = state_ff.progStrobe;
	assign flashProgAddr   = state_ff.progAddr;
	assign flashProgData   = state_ff.progData;
	// erase side and data RAM store
	assign pageEraseStart  = state_ff.pageStart;
	assign massEraseStart  = state_ff.massStart;
	assign erasePage       = state_ff.erPage;
	assign eraseBusy       = state_ff.busy;
	assign dataRamStore    = state_ff.ramStore;
endmodule

/* common/fbepc_pkg.sv */
// constants and types for the flash bank, erase and program-write control block
package fbepc_pkg;
	localparam logic [13:0] ERASE_COMMAND_ADDR  = 14'h0094;
	localparam logic [13:0] PROG_CTRL_ADDR      = 14'h00B2;
	localparam logic [13:0] BANK_SELECT_ADDR    = 14'h00B6;
	localparam logic [13:0] PAGE_ERASE_ADDR     = 14'h00B7;
	localparam logic [13:0] FUSE_CTRL_ADDR      = 14'h20FD;
	localparam int          PWE_BIT             = 0;
	localparam int          ARM_BIT             = 1;
	localparam int          PAGE_LSB            = 2;
	localparam int          FOVR_BIT            = 4;
	localparam logic [7:0]  PAGE_ERASE_PATTERN  = 8'h55;
	localparam logic [7:0]  MASS_ERASE_PATTERN  = 8'hAA;
	localparam logic [7:0]  ERASE_DONE_PATTERN  = 8'h00;
	localparam int          BANK_WIDTH          = 3;
	localparam logic [2:0]  BANK_RESET          = 3'h1;
	localparam int          PAGE_WIDTH          = 6;
	localparam logic [5:0]  PAGE_RESET          = 6'h00;
	localparam int          OFFSET_WIDTH        = 15;
	localparam int          FLASH_ADDR_WIDTH    = 18;
	localparam int          FUSE_WIDTH          = 8;
	localparam int          ERASE_BUSY_CYCLES   = 16;
	typedef enum logic [1:0] {FBEPC_IDLE, FBEPC_PAGE, FBEPC_MASS} fbepc_erase_type;
endpackage

/* verilog/fbepc_addr_map.sv */
// code-space to flash address mapping through the bank select field
`timescale 1ns/1ps
module fbepc_addr_map #(
	parameter int BANK_W = 3
) (
	// core side
	input  wire logic [15:0]                     coreAddr,
	input  wire logic [BANK_W-1:0]               bankSel,
	// flash side
	output logic [BANK_W+14:0]                   flashAddr
);
	// upper window banked; bank over offset
	always_comb begin
		if (coreAddr[15]) begin
			flashAddr = {bankSel, coreAddr[14:0]};
		end else begin
			flashAddr = {{BANK_W{1'b0}}, coreAddr[14:0]};
		end
	end
endmodule

/* test/fbepc_core_model.sv */
// core model: firmware register accesses and external-data stores
`timescale 1ns/1ps
module fbepc_core_model (
	input  wire logic       sys_clk,
	output logic [13:0]     regAddr,
	output logic            regWrite,
	output logic            regRead,
	output logic [7:0]      regWdata,
	input  wire logic [7:0] regRdata,
	output logic [15:0]     dataPointer,
	output logic [7:0]      accumulator,
	output logic            xdataStore
);
	initial {regAddr, regWrite, regRead, regWdata, dataPointer, accumulator, xdataStore} = '0;
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge sys_clk);
		regWrite = 1'b0;
		regWdata = ~d;
	endtask
	task automatic rd(input logic [13:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge sys_clk);
		regRead = 1'b0;
		d = regRdata;
	endtask
	task automatic store(input logic [15:0] p, input logic [7:0] v);
		@(negedge sys_clk);
		dataPointer = p;
		accumulator = v;
		xdataStore = 1'b1;
		@(negedge sys_clk);
		xdataStore = 1'b0;
	endtask
endmodule

/* test/fbepc_ctrl_asserts.sv */
// port assertions for the flash control block
`timescale 1ns/1ps
module fbepc_ctrl_asserts #(
	parameter int BUSY_CYCLES = 16
) (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic [13:0] regAddr,
	input wire logic        regWrite,
	input wire logic [7:0]  regWdata,
	input wire logic        debugPortEnable,
	input wire logic [15:0] codeAddr,
	input wire logic        xdataStore,
	input wire logic [17:0] flashReadAddr,
	input wire logic        flashProgStrobe,
	input wire logic        pageEraseStart,
	input wire logic        massEraseStart,
	input wire logic        eraseBusy,
	input wire logic        dataRamStore
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire cmdW = regWrite && regAddr == 14'h0094;
	wire badCmd = cmdW && !(regWdata inside {8'h55, 8'hAA});
	wire anyStart = pageEraseStart || massEraseStart;
	sequence cmd(p);
		cmdW && regWdata == p;
	endsequence
	AST_PAGE_GO: assert property (cmd(8'h55) ##0 !eraseBusy |=> pageEraseStart && eraseBusy)
		else $error("page erase not launched");
	AST_BUSY_HOLD: assert property (eraseBusy && !(cmdW && regWdata == 8'h00) |=> eraseBusy)
		else $error("erase ended early");
	AST_BAD_CMD: assert property (badCmd |=> !anyStart)
		else $error("erase from bad pattern");
	AST_MASS_DBG: assert property (massEraseStart |-> $past(debugPortEnable && cmdW))
		else $error("mass erase without debug port");
	AST_ONE_SHOT: assert property (anyStart |=> !anyStart)
		else $error("erase launched twice");
	AST_CODE_MAP: assert property (1'b1 |=> flashReadAddr[14:0] == $past(codeAddr[14:0]))
		else $error("code offset not passed");
	AST_ST_ROUTE: assert property (xdataStore |=> flashProgStrobe != dataRamStore)
		else $error("store routed wrong");
	AST_ST_CAUSE: assert property (flashProgStrobe || dataRamStore |-> $past(xdataStore))
		else $error("store without request");
endmodule
bind fbepc_ctrl fbepc_ctrl_asserts #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (
	.sys_clk         (sys_clk),
	.rstn            (rstn),
	.regAddr         (regAddr),
	.regWrite        (regWrite),
	.regWdata        (regWdata),
	.debugPortEnable (debugPortEnable),
	.codeAddr        (codeAddr),
	.xdataStore      (xdataStore),
	.flashReadAddr   (flashReadAddr),
	.flashProgStrobe (flashProgStrobe),
	.pageEraseStart  (pageEraseStart),
	.massEraseStart  (massEraseStart),
	.eraseBusy       (eraseBusy),
	.dataRamStore    (dataRamStore)
);

/* test/tb_flash_bank_erase_program_ctrl.sv */
// self-checking bench for the flash bank, erase and program-write block
`timescale 1ns/1ps
module tb_flash_bank_erase_program_ctrl;
	localparam int BUSY = 2;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        intEnable = 1'b0;
	logic        debugPortEnable = 1'b0;
	logic [15:0] codeAddr = 16'h0000;
	logic [7:0]  fuseValue = 8'h00;
	logic [13:0] regAddr;
	logic [15:0] dataPointer;
	logic [17:0] flashReadAddr, flashProgAddr;
	logic [7:0]  regWdata, regRdata, accumulator, fuseEffective, flashProgData, rdat;
	logic [6:0]  erasePage;
	logic        regWrite, regRead, xdataStore, flashProgStrobe, pageEraseStart;
	logic        massEraseStart, eraseBusy, dataRamStore;
	int          fail_count = 0, checks_done = 0, cycles = 0, bank = 1, arm = 0, pg;
	fbepc_core_model core (.*);
	fbepc_ctrl #(.BUSY_CYCLES(BUSY)) DUT (.*);
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 3000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic launch(input logic [7:0] pat);
		logic isPg;
		logic isMs;
		isPg = pat == 8'h55;
		isMs = pat == 8'hAA && arm == 1 && debugPortEnable;
		if (isMs) arm = 0;
		core.wr(14'h0094, pat);
		check(18'(pageEraseStart), 18'(isPg));
		check(18'(massEraseStart), 18'(isMs));
		check(18'(eraseBusy), 18'(isPg || isMs));
		if (isPg) check(18'(erasePage), 18'({bank[0], pg[5:0]}));
		if (isPg || isMs) begin
			bank = 1;
			core.wr(14'h0094, 8'h00);
			check(18'(eraseBusy), 18'h1);
			repeat (BUSY + 2) @(negedge sys_clk);
			core.wr(14'h0094, 8'h00);
		end
		check(18'(eraseBusy), 18'h0);
		core.rd(14'h00B6, rdat);
		check(18'(rdat), 18'(bank));
	endtask
	task automatic st(input int pwe);
		logic [15:0] p;
		logic [7:0]  a;
		p = 16'($urandom);
		a = 8'($urandom);
		core.store(p, a);
		check(18'(dataRamStore), 18'(pwe == 0));
		check(18'(flashProgStrobe), 18'(pwe));
		if (pwe) check(flashProgAddr, 18'({p[15] ? bank[2:0] : 3'h0, p[14:0]}));
		if (pwe) check(18'(flashProgData), 18'(a));
	endtask
	initial begin
		void'($urandom(99008));
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		core.rd(14'h00B6, rdat);
		check(18'(rdat), 18'h1);
		for (int i = 0; i < 4; i++) begin
			bank = $urandom % 8;
			core.wr(14'h00B6, 8'(bank));
			codeAddr = 16'($urandom);
			@(negedge sys_clk);
			check(flashReadAddr, 18'({codeAddr[15] ? bank[2:0] : 3'h0, codeAddr[14:0]}));
			pg = $urandom % 64;
			core.wr(14'h00B7, 8'(pg << 2));
			launch(8'h55);
		end
		bank = 6;
		core.wr(14'h00B6, 8'h06);
		launch(8'h5A);
		launch(8'hAA);
		arm = 1;
		core.wr(14'h00B2, 8'h02);
		launch(8'hAA);
		debugPortEnable = 1'b1;
		arm = 1;
		core.wr(14'h00B2, 8'h02);
		launch(8'hAA);
		launch(8'hAA);
		intEnable = 1'b1;
		core.wr(14'h00B2, 8'h01);
		st(0);
		intEnable = 1'b0;
		core.wr(14'h00B2, 8'h01);
		st(1);
		core.wr(14'h00B2, 8'h00);
		st(0);
		fuseValue = 8'($urandom);
		repeat (3) @(negedge sys_clk);
		check(18'(fuseEffective), 18'(fuseValue));
		pg = $urandom % 256 | 16;
		core.wr(14'h20FD, 8'h10);
		core.wr(14'h20FD, 8'(pg));
		@(negedge sys_clk);
		check(18'(fuseEffective), 18'(pg));
		core.rd(14'h20FD, rdat);
		check(18'(rdat), 18'h10);
		core.wr(14'h20FD, 8'h00);
		@(negedge sys_clk);
		check(18'(fuseEffective), 18'(fuseValue));
		conclude();
	end
endmodule
